/* include/flash_pkg.sv */
package flash_pkg;

  // ****************************************
  // Instruction codes
  // ****************************************
  localparam logic [7:0] OP_DUAL_IO    = 8'hbb;
  localparam logic [7:0] OP_QUAD_IO    = 8'heb;
  localparam logic [7:0] OP_WORD_QUAD  = 8'he3;
  localparam logic [7:0] OP_PAGE_PROG  = 8'h02;
  localparam logic [7:0] OP_READ_SR1   = 8'h05;
  localparam logic [7:0] OP_READ_SR2   = 8'h35;
  localparam logic [7:0] OP_WRITE_EN   = 8'h06;
  localparam logic [7:0] OP_MODE_RESET = 8'hff;
  localparam logic [3:0] CONT_KEEP     = 4'ha;

  // ****************************************
  // Frame geometry and timing
  // ****************************************
  localparam logic [5:0] ADDR_BITS       = 6'h18;
  localparam logic [5:0] BYTE_BITS       = 6'h08;
  localparam logic [5:0] QUAD_DUMMY_CLKS = 6'h04;
  localparam int         PAGE_BYTES      = 256;
  localparam int         CLK_PERIOD_NS   = 10;
  localparam int         PROG_TIME_US    = 700;
  localparam int         PROG_CYCLES_DEF = PROG_TIME_US * 1000 / CLK_PERIOD_NS;

  // ****************************************
  // Local register port map
  // ****************************************
  localparam logic [3:0]  REG_CONTROL   = 4'h0;
  localparam logic [3:0]  REG_STATUS    = 4'h4;
  localparam int          CTL_BP_LSB    = 0;
  localparam int          CTL_QE_BIT    = 3;
  localparam int          CTL_WEL_BIT   = 4;
  localparam logic [2:0]  BP_RESET      = 3'h0;
  localparam logic        QE_RESET      = 1'b0;
  localparam int          STAT_BUSY_BIT = 0;
  localparam int          STAT_WEL_BIT  = 1;
  localparam int          STAT_CONT_BIT = 2;

  typedef enum {ST_IDLE, ST_OPCODE, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_STATUS,
                ST_PROG, ST_WREN, ST_IGNORE} state_t;

  function automatic logic [23:0] shift_in(input logic [23:0] s, input logic [3:0] l,
                                           input logic [1:0] lw);
    case (lw)
      2'd2: return {s[19:0], l};
      2'd1: return {s[21:0], l[1:0]};
      default: return {s[22:0], l[0]};
    endcase
  endfunction

  function automatic logic [5:0] phase_clocks(input logic [5:0] bits, input logic [1:0] lw);
    return bits >> lw;
  endfunction

  // Higher bits go on higher lanes; single lane output leaves on lane1
  function automatic logic [3:0] out_group(input logic [7:0] b, input logic [1:0] lw);
    case (lw)
      2'd2: return b[7:4];
      2'd1: return {2'h0, b[7:6]};
      default: return {2'h0, b[7], 1'b0};
    endcase
  endfunction

  function automatic logic [3:0] drive_mask_n(input logic [1:0] lw);
    case (lw)
      2'd2: return 4'h0;
      2'd1: return 4'hc;
      default: return 4'hd;
    endcase
  endfunction

  // Upper 64 KB blocks of a 2 MB array are protected, growing with the code
  function automatic logic page_protected(input logic [23:0] a, input logic [2:0] bp);
    logic [5:0] span;
    span = 6'h01 << (bp - 3'h1);
    if (bp == 3'h0)
      return 1'b0;
    if (bp == 3'h7)
      return 1'b1;
    return {1'b0, a[20:16]} >= (6'h20 - span);
  endfunction

endpackage

/* hw/pin_sync.sv */
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk) begin
    if (reset) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule

/* hw/page_buffer.sv */
`timescale 1ns/1ns
module page_buffer #(
  parameter int DEPTH = 256,
  parameter int DW    = 8,
  parameter int AW    = 8
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          clear,
  input  wire logic          wr,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          rd,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata,
  output logic               rvalid
);
  logic [DW-1:0]    mem [DEPTH];
  logic [DEPTH-1:0] filled;

  // Only bytes received in this frame are marked, so a partial page leaves the rest alone
  always_ff @(posedge clk) begin
    if (reset || clear) begin
      filled <= '0;
    end else if (wr) begin
      filled[waddr] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (wr) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata  <= '0;
      rvalid <= 1'b0;
    end else begin
      rdata  <= mem[raddr];
      rvalid <= rd && filled[raddr];
    end
  end
endmodule

/* hw/flash_cmd_engine.sv */
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
// Behaviour
// RQ1: BBh takes address two bits per clock
// RQ2: Continuation byte follows address; low nibble ignored
// RQ3: Dual read upper nibble A skips next opcode
// RQ4: Other continuation values restore opcode decoding
// RQ5: Mode reset instruction clears stored continuation
// RQ6: Host releases lanes before first data edge
// RQ7: EBh quad address, four dummy clocks, data
// RQ8: EBh only accepted with four-lane enable
// RQ9: Quad read nibble A skips EBh next
// RQ10: Host gives E3h address low nibble zero
// RQ11: E3h data follows continuation without dummies
// RQ12: E3h only accepted with four-lane enable
// RQ13: E3h nibble A skips opcode next time
// RQ14: Page program needs write latch set
// RQ15: Host sends opcode, address, data, select low
// RQ16: Program offset wraps within 256-byte page
// RQ17: Partial page leaves other bytes untouched
// RQ18: Select must rise on byte boundary
// RQ19: Busy high for program time after commit
// RQ20: Status read still works while busy
// RQ21: Write latch cleared when program finishes
// RQ22: Protected pages are never programmed
// RQ23: 05h and 35h shift status MSB first
// RQ24: Four-lane enable bit 9, protect bit 8; here bit 8 of the status always reads as zero
// RQ25: Continuation state cleared at reset
// RQ26: Higher bits on higher lanes, MSB first
module flash_cmd_engine
  import flash_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic [3:0]  lane_in,
  output logic      [3:0]  lane_out,
  output logic      [3:0]  lane_oe_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic      [23:0] mem_addr,
  input  wire logic [7:0]  mem_rdata,
  output logic             prog_we,
  output logic      [23:0] prog_addr,
  output logic      [7:0]  prog_data
);

  // ****************************************
  // Pin sampling and edge detection
  // ****************************************
  logic [5:0] pins_s;
  logic       sclk_d;
  logic       cs_n_d;

  // Select is synced as active high, so the cleared chain reads as deselected
  pin_sync #(.WIDTH(6)) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({sclk, ~cs_n, lane_in}),
    .q     (pins_s)
  );

  wire       sclk_s  = pins_s[5];
  wire       cs_n_s  = ~pins_s[4];
  wire [3:0] lanes_s = pins_s[3:0];

  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      cs_n_d <= cs_n_s;
    end
  end

  wire rise    = sclk_s && !sclk_d && !cs_n_s;
  wire fall    = !sclk_s && sclk_d && !cs_n_s;
  wire cs_fall = !cs_n_s && cs_n_d;
  wire cs_rise = cs_n_s && !cs_n_d;

  // ****************************************
  // Frame state
  // ****************************************
  state_t      state;
  state_t      next_state;
  logic [7:0]  op;
  logic [1:0]  lw;
  logic [5:0]  cnt;
  logic [23:0] sh;
  logic [23:0] addr_r;
  logic [7:0]  out_byte;
  logic [2:0]  grp;
  logic        cont_valid;
  logic [7:0]  cont_op;
  logic        busy;
  logic        write_latch_flag;
  logic [2:0]  bp;
  logic        qe;
  logic [15:0] prog_page;
  logic [7:0]  prog_off;
  logic        prog_seen;
  logic [31:0] busy_cnt;
  logic [7:0]  idx_d;

  wire [23:0] sh_next = shift_in(sh, lanes_s, lw);
  wire [7:0]  opcode  = sh_next[7:0];
  wire [5:0]  phase_len = (state == ST_ADDR)  ? phase_clocks(ADDR_BITS, lw) :
                          (state == ST_MODE)  ? phase_clocks(BYTE_BITS, lw) :
                          (state == ST_DUMMY) ? QUAD_DUMMY_CLKS : BYTE_BITS;
  wire        last     = rise && (cnt == phase_len - 6'h01);
  wire        op_done  = last && (state == ST_OPCODE);
  wire        is_quad  = (opcode == OP_QUAD_IO) || (opcode == OP_WORD_QUAD);
  wire        commit   = cs_rise && (state == ST_PROG) && (cnt == 6'h00) && prog_seen &&
                         !page_protected({prog_page, 8'h00}, bp);
  wire        wren_hit = cs_rise && (state == ST_WREN) && (cnt == 6'h00);
  wire        byte_in  = last && (state == ST_PROG);
  wire        stream   = busy && (busy_cnt < 32'(PAGE_BYTES));
  wire [7:0]  sr1      = {3'h0, bp, write_latch_flag, busy};
  wire [7:0]  sr2      = {6'h00, qe, 1'b0};                   // see RQ24
  wire [1:0]  out_lw   = (state == ST_STATUS) ? 2'd0 : lw;
  wire [2:0]  grp_last = 3'(3'h7 >> out_lw);
  wire [7:0]  src_byte = (state == ST_STATUS) ? ((op == OP_READ_SR2) ? sr2 : sr1) : mem_rdata;
  wire [7:0]  cur_byte = (grp == 3'h0) ? src_byte : out_byte;
  wire        sw_wel   = reg_wr && (reg_addr == REG_CONTROL);

  // ****************************************
  // Instruction decode
  // ****************************************
  always_comb begin
    next_state = state;
    if (cs_n_s) begin
      next_state = ST_IDLE;
    end else if (cs_fall) begin
      if (cont_valid && !busy) begin
        next_state = ST_ADDR;                                  // see RQ3
      end else if (cont_valid) begin
        next_state = ST_IGNORE;
      end else begin
        next_state = ST_OPCODE;                                // see RQ4
      end
    end else if (last) begin
      case (state)
        ST_OPCODE: begin
          if (busy && opcode != OP_READ_SR1 && opcode != OP_READ_SR2) begin
            next_state = ST_IGNORE;                            // see RQ20
          end else begin
            case (opcode)
              OP_DUAL_IO: next_state = ST_ADDR;                // see RQ1
              OP_QUAD_IO, OP_WORD_QUAD: next_state = qe ? ST_ADDR : ST_IGNORE; // see RQ8 see RQ12
              OP_PAGE_PROG: next_state = write_latch_flag ? ST_ADDR : ST_IGNORE; // see RQ14
              OP_READ_SR1, OP_READ_SR2: next_state = ST_STATUS; // see RQ23
              OP_WRITE_EN: next_state = ST_WREN;
              default: next_state = ST_IGNORE;
            endcase
          end
        end
        ST_ADDR: next_state = (op == OP_PAGE_PROG) ? ST_PROG : ST_MODE;
        ST_MODE: next_state = (op == OP_QUAD_IO) ? ST_DUMMY : ST_DATA; // see RQ7 see RQ11
        ST_DUMMY: next_state = ST_DATA;
        ST_WREN: next_state = ST_IGNORE;
        default: next_state = state;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      op <= 8'h00;
      lw <= 2'd0;
    end else if (cs_fall) begin
      op <= cont_valid ? cont_op : 8'h00;
      lw <= !cont_valid ? 2'd0 : (cont_op == OP_DUAL_IO) ? 2'd1 : 2'd2;
    end else if (op_done) begin
      op <= opcode;
      lw <= (opcode == OP_DUAL_IO) ? 2'd1 : is_quad ? 2'd2 : 2'd0;
    end
  end

  // Continuation state: set by a read's mode byte; a frame cut off in its address drops it
  always_ff @(posedge clk) begin
    if (reset) begin
      cont_valid <= 1'b0;                                      // see RQ25
      cont_op    <= 8'h00;
    end else if ((op_done && opcode == OP_MODE_RESET) || (cs_rise && state == ST_ADDR)) begin
      cont_valid <= 1'b0;                                      // see RQ5
    end else if (last && state == ST_MODE) begin
      cont_valid <= (sh_next[7:4] == CONT_KEEP);               // see RQ2 see RQ9 see RQ13
      cont_op    <= op;
    end
  end

  // ****************************************
  // Shift path and counters
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset || cs_n_s) begin
      cnt <= 6'h00;
      sh  <= 24'h000000;
    end else if (rise) begin
      cnt <= last ? 6'h00 : cnt + 6'h01;
      sh  <= sh_next;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      addr_r <= 24'h000000;
    end else if (last && state == ST_ADDR) begin
      addr_r <= sh_next;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mem_addr <= 24'h000000;
    end else if (last && state == ST_MODE) begin
      mem_addr <= addr_r;
    end else if (fall && state == ST_DATA && grp == 3'h0) begin
      mem_addr <= mem_addr + 24'h000001;
    end
  end

  // ****************************************
  // Lane output
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset || cs_n_s) begin
      lane_out  <= 4'h0;
      lane_oe_n <= 4'hf;
      out_byte  <= 8'h00;
      grp       <= 3'h0;
    end else if (fall && (state == ST_DATA || state == ST_STATUS)) begin
      lane_out  <= out_group(cur_byte, out_lw);               // see RQ26
      lane_oe_n <= drive_mask_n(out_lw);                       // see RQ6
      out_byte  <= cur_byte << (4'h1 << out_lw);
      grp       <= (grp == grp_last) ? 3'h0 : grp + 3'h1;
    end
  end

  // ****************************************
  // Page program
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      prog_page <= 16'h0000;
      prog_off  <= 8'h00;
      prog_seen <= 1'b0;
    end else if (last && state == ST_ADDR) begin
      prog_page <= sh_next[23:8];
      prog_off  <= sh_next[7:0];
      prog_seen <= 1'b0;
    end else if (byte_in) begin
      prog_off  <= prog_off + 8'h01;                           // see RQ16
      prog_seen <= 1'b1;
    end
  end

  page_buffer #(.DEPTH(PAGE_BYTES), .DW(8), .AW(8)) u_page (
    .clk    (clk),
    .reset  (reset),
    .clear  (last && state == ST_ADDR),
    .wr     (byte_in),
    .waddr  (prog_off),
    .wdata  (sh_next[7:0]),
    .rd     (stream),
    .raddr  (busy_cnt[7:0]),
    .rdata  (prog_data),
    .rvalid (prog_we)                                          // see RQ17
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      idx_d <= 8'h00;
    end else begin
      idx_d <= busy_cnt[7:0];
    end
  end

  assign prog_addr = {prog_page, idx_d};

  always_ff @(posedge clk) begin
    if (reset) begin
      busy     <= 1'b0;
      busy_cnt <= 32'h00000000;
    end else if (commit) begin
      busy     <= 1'b1;                                        // see RQ18 see RQ22
      busy_cnt <= 32'h00000000;
    end else if (busy) begin
      busy     <= (busy_cnt != 32'(PROG_CYCLES - 1));          // see RQ19
      busy_cnt <= busy_cnt + 32'h00000001;
    end
  end

  // ****************************************
  // Local register port
  // ****************************************
  wire busy_end = busy && (busy_cnt == 32'(PROG_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (reset) begin
      write_latch_flag <= 1'b0;
      bp  <= BP_RESET;
      qe  <= QE_RESET;
    end else begin
      if (sw_wel) begin
        write_latch_flag <= reg_wdata[CTL_WEL_BIT];
        bp  <= reg_wdata[CTL_BP_LSB +: 3];
        qe  <= reg_wdata[CTL_QE_BIT];
      end else if (wren_hit) begin
        write_latch_flag <= 1'b1;
      end else if (busy_end) begin
        write_latch_flag <= 1'b0;                                           // see RQ21
      end
    end
  end

  wire [31:0] ctl_word  = {27'h0, write_latch_flag, qe, bp};
  wire [31:0] stat_word = {29'h0, cont_valid, write_latch_flag, busy};
  wire [31:0] rd_word   = (reg_addr == REG_CONTROL) ? ctl_word :
                          (reg_addr == REG_STATUS)  ? stat_word : 32'h00000000;

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= reg_rd ? rd_word : 32'h00000000;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [31:0] busy_len;

  always_ff @(posedge clk) begin
    if (reset || !busy) begin
      busy_len <= 32'h00000000;
    end else begin
      busy_len <= busy_len + 32'h00000001;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_prog_needs_wel: assert property ($rose(busy) |-> $past(write_latch_flag)) // see RQ14
    else $error("program started without write latch");
  a_busy_length: assert property ($fell(busy) |-> busy_len == 32'(PROG_CYCLES)) // see RQ19
    else $error("program cycle length wrong");
  a_busy_clears_wel: assert property ($fell(busy) && !$past(sw_wel) |-> !write_latch_flag) // see RQ21
    else $error("write latch left set after program");
  a_prog_protect: assert property ($rose(busy) |-> !page_protected({prog_page, 8'h00}, bp)) // see RQ22
    else $error("protected page programmed");
  a_byte_boundary: assert property ($rose(busy) |-> $past(cnt) == 6'h00 && $past(cs_rise)) // see RQ18
    else $error("program committed off byte boundary");
  a_cont_skip: assert property (cs_fall && cont_valid && !busy |=> state == ST_ADDR && lw != 2'd0) // see RQ3
    else $error("continuation did not skip opcode");
  a_opcode_expect: assert property (cs_fall && !cont_valid |=> state == ST_OPCODE ##1 lw == 2'd0) // see RQ4
    else $error("opcode phase not entered");
  a_quad_gate: assert property (op_done && is_quad && !qe && !busy |=> state == ST_IGNORE) // see RQ8
    else $error("quad read accepted without enable");
  a_page_wrap: assert property (byte_in && prog_off == 8'hff |=> prog_off == 8'h00) // see RQ16
    else $error("page offset did not wrap");
  a_mode_reset: assert property ((op_done && opcode == OP_MODE_RESET) || (cs_rise && state == ST_ADDR) |=> !cont_valid) // see RQ5
    else $error("mode reset left continuation");
endmodule

/* verif/spi_host_model.sv */
`timescale 1ns/1ns
module spi_host_model (
  input  wire logic       clk,
  input  wire logic [3:0] lane_wire,
  output logic            sclk,
  output logic            cs_n,
  output logic      [3:0] host_do,
  output logic      [3:0] host_oe_n
);
  initial begin
    sclk      = 1'b0;
    cs_n      = 1'b1;
    host_do   = 4'h0;
    host_oe_n = 4'hf;
  end

  // ****************************************
  // Serial clock, low outside frames
  // ****************************************
  task automatic tick(input logic rel, output logic [3:0] w);
    repeat (8) @(posedge clk);
    w = lane_wire;
    sclk <= 1'b1;
    repeat (4) @(posedge clk);
    if (rel) begin
      host_oe_n <= 4'hf;
    end
    repeat (4) @(posedge clk);
    sclk <= 1'b0;
  endtask

  task automatic start();
    cs_n <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  task automatic stop();
    repeat (8) @(posedge clk);
    cs_n      <= 1'b1;
    host_oe_n <= 4'hf;
    repeat (12) @(posedge clk);
  endtask

  // ****************************************
  // Shifting; lw is log2 of the lane count
  // ****************************************
  task automatic send(input logic [31:0] v, input int nbits, input logic [1:0] lw, input logic rel);
    logic [31:0] s;
    logic [3:0]  w;
    s = v << (32 - nbits);
    for (int i = 0; i < nbits; i += (1 << lw)) begin
      host_oe_n <= (lw == 2'd2) ? 4'h0 : (lw == 2'd1) ? 4'hc : 4'he;
      host_do   <= (lw == 2'd2) ? s[31:28] : (lw == 2'd1) ? {2'h0, s[31:30]} : {3'h0, s[31]};
      s = s << (1 << lw);
      tick(rel && (i + (1 << lw) >= nbits), w);
    end
  endtask

  task automatic recv(output logic [7:0] b, input logic [1:0] lw);
    logic [3:0] w;
    b = 8'h00;
    for (int i = 0; i < (8 >> lw); i++) begin
      tick(1'b1, w);
      b = (lw == 2'd2) ? {b[3:0], w} : (lw == 2'd1) ? {b[5:0], w[1:0]} : {b[6:0], w[1]};
    end
  endtask
endmodule

/* verif/serial_flash_fastread_program_tb.sv */
`timescale 1ns/1ns
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin bad_count++; \
  $display("[ERR] %0t got=%h exp=%h", $time, (got), (exp)); end end
module serial_flash_fastread_program_tb
  import flash_pkg::*;
;
  localparam int PROG_SIM = 300;
  logic        clk;
  logic        reset;
  logic        sclk;
  logic        cs_n;
  logic        tog;
  logic [3:0]  host_do;
  logic [3:0]  host_oe_n;
  logic [3:0]  lane_out;
  logic [3:0]  lane_oe_n;
  logic [3:0]  lane_wire;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [23:0] mem_addr;
  logic [7:0]  mem_rdata;
  logic        prog_we;
  logic [23:0] prog_addr;
  logic [7:0]  prog_data;
  logic [7:0]  pmem [0:255];
  logic [15:0] ppage;
  logic [31:0] d;
  logic [7:0]  b;
  int          pcount;
  int          bad_count;
  int          compares;
  logic [7:0]  ops [0:2] = '{OP_DUAL_IO, OP_QUAD_IO, OP_WORD_QUAD};
  logic [1:0]  lws [0:2] = '{2'd1, 2'd2, 2'd2};
  int          nds [0:2] = '{0, 4, 0};

  function automatic logic [7:0] mb(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction

  always #5 clk = ~clk;
  always @(posedge clk) tog <= ~tog;
  // Released lanes show a changing level, never the last value
  assign lane_wire = (~lane_oe_n & lane_out) | (lane_oe_n & ~host_oe_n & host_do) | (lane_oe_n & host_oe_n & {4{tog}});
  assign mem_rdata = mb(mem_addr);

  always @(posedge clk) begin
    if (prog_we) begin
      pmem[prog_addr[7:0]] <= prog_data;
      ppage                <= prog_addr[23:8];
      pcount++;
    end
  end

  flash_cmd_engine #(.PROG_CYCLES(PROG_SIM)) DUT (
    .clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .lane_in(lane_wire), .lane_out(lane_out),
    .lane_oe_n(lane_oe_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .prog_we(prog_we),
    .prog_addr(prog_addr), .prog_data(prog_data)
  );
  spi_host_model host (
    .clk(clk), .lane_wire(lane_wire), .sclk(sclk), .cs_n(cs_n), .host_do(host_do), .host_oe_n(host_oe_n)
  );

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    q = reg_rdata;
    @(posedge clk);
  endtask

  // A zero opcode means the frame starts at the address
  task automatic rframe(input logic [7:0] op, input logic [23:0] a, input logic [7:0] m,
                        input logic [1:0] lw, input int nd, input int n);
    logic [3:0] w;
    logic [7:0] q;
    host.start();
    if (op != 8'h00) begin
      host.send(op, 8, 2'd0, 1'b0);
    end
    host.send({a, m}, 32, lw, 1'b1);
    repeat (nd) host.tick(1'b1, w);
    for (int i = 0; i < n; i++) begin
      host.recv(q, lw);
      `CHECK(q, mb(a + 24'(i)))
    end
    host.stop();
  endtask

  task automatic sframe(input logic [7:0] op, output logic [7:0] q);
    host.start();
    host.send(op, 8, 2'd0, 1'b1);
    host.recv(q, 2'd0);
    host.stop();
  endtask

  task automatic pframe(input logic [23:0] a, input int n, input int extra);
    host.start();
    host.send(OP_PAGE_PROG, 8, 2'd0, 1'b0);
    host.send(a, 24, 2'd0, 1'b0);
    for (int i = 0; i < n; i++) host.send(8'h30 + i, 8, 2'd0, 1'b0);
    if (extra > 0) begin
      host.send(32'h0, extra, 2'd0, 1'b0);
    end
    host.stop();
  endtask

  task automatic wait_idle();
    int i;
    for (i = 0; i < 300; i++) begin
      rd(REG_STATUS, d);
      if (d[STAT_BUSY_BIT] === 1'b0) break;
    end
    if (i == 300) begin
      bad_count++;
      conclude();
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clk       = 1'b0;
    reset     = 1'b1;
    tog       = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    pcount    = 0;
    bad_count = 0;
    compares  = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    rd(REG_CONTROL, d);
    `CHECK(d, 32'h0)
    rd(REG_STATUS, d);
    `CHECK(d, 32'h0)
    wr(4'h8, 32'hffffffff);
    rd(4'h8, d);
    `CHECK(d, 32'h0)
    for (int k = 1; k < 3; k++) begin
      rframe(ops[k], 24'h000400, 8'ha5, 2'd2, nds[k], 0);
      rd(REG_STATUS, d);
      `CHECK(d[STAT_CONT_BIT], 1'b0)
    end
    wr(REG_CONTROL, 32'h8);
    // Word-aligned addresses keep the low nibble zero
    for (int k = 0; k < 3; k++) begin
      rframe(ops[k], 24'h000400 + 24'(k * 16), 8'ha5, lws[k], nds[k], 2);
      rd(REG_STATUS, d);
      `CHECK(d[STAT_CONT_BIT], 1'b1)
      rframe(8'h00, 24'h000800 + 24'(k * 16), 8'h3c, lws[k], nds[k], 1);
      rd(REG_STATUS, d);
      `CHECK(d[STAT_CONT_BIT], 1'b0)
    end
    rframe(ops[0], 24'h000c00, 8'ha5, lws[0], nds[0], 1);
    host.start();
    host.send(OP_MODE_RESET, 8, 2'd0, 1'b0);
    host.stop();
    rd(REG_STATUS, d);
    `CHECK(d[STAT_CONT_BIT], 1'b0)
    sframe(OP_READ_SR2, b);
    `CHECK(b, 8'h02)
    pframe(24'h0012fe, 3, 0);
    rd(REG_STATUS, d);
    `CHECK(d[STAT_BUSY_BIT], 1'b0)
    `CHECK(pcount, 0)
    host.start();
    host.send(OP_WRITE_EN, 8, 2'd0, 1'b0);
    host.stop();
    pframe(24'h0012fe, 3, 0);
    sframe(OP_READ_SR1, b);
    `CHECK(b, 8'h03)
    wait_idle();
    `CHECK(d[STAT_WEL_BIT], 1'b0)
    `CHECK(pcount, 3)
    `CHECK(ppage, 16'h0012)
    `CHECK(pmem[8'hfe], 8'h30)
    `CHECK(pmem[8'hff], 8'h31)
    `CHECK(pmem[8'h00], 8'h32)
    wr(REG_CONTROL, 32'h18);
    pframe(24'h000100, 1, 4);
    rd(REG_STATUS, d);
    `CHECK(d[STAT_BUSY_BIT], 1'b0)
    wr(REG_CONTROL, 32'h1f);
    pframe(24'h000000, 1, 0);
    rd(REG_STATUS, d);
    `CHECK(d[STAT_BUSY_BIT], 1'b0)
    repeat (PROG_SIM) @(posedge clk);
    `CHECK(pcount, 3)
    conclude();
  end
endmodule
